//--- shared/twrg_consts.svh
/*
  Constants of the two-wire interface register write guard: offsets,
  field positions, reset values and the password.
  Assumes an APB slave with 8-bit byte addresses and 32-bit data.
*/
// What this block does
// - A mode write with the right password and bit 0 low turns protection off.
// - A mode write with the right password and bit 0 high turns protection on.
// - A mode write with any other key is dropped and the enable bit is kept.
// - A write protection violation sets the violation flag until the next status read.
// - Reading the status register clears the flag, so it reads 0 with no new violation.
// - While the flag is set, status bits 31:8 show the offset of the offending write.
// - The source field loads only on a write attempt to a protected register.
`ifndef TWRG_CONSTS_SVH
`define TWRG_CONSTS_SVH

`define TWRG_OFS_CTRL       8'h00
`define TWRG_OFS_CFG        8'h04
`define TWRG_OFS_MODE       8'hE4
`define TWRG_OFS_STATUS     8'hE8
`define TWRG_OFS_IRQ_STATUS 8'hF0
`define TWRG_OFS_IRQ_MASK   8'hF4

`define TWRG_PASSWORD       24'h54_5749
`define TWRG_KEY_MSB        31
`define TWRG_KEY_LSB        8
`define TWRG_EN_BIT         0
`define TWRG_FLAG_BIT       0
`define TWRG_SRC_MSB        31
`define TWRG_SRC_LSB        8
`define TWRG_IRQ_VIOL_BIT   0

`define TWRG_RST_WORD       32'h0000_0000
`define TWRG_RST_SRC        24'h00_0000
`define TWRG_RST_IRQ        1'h0

`endif

//--- shared/twrg_pkg.sv
/*
  Types of the two-wire interface register write guard.
  Assumes the constants header is included by the design files.
*/
package twrg_pkg;
  typedef logic [7:0]  twrg_addr_t;
  typedef logic [31:0] twrg_word_t;
  typedef logic [23:0] twrg_src_t;
endpackage

//--- design/twrg_top.sv
/*
  Register write guard with two protected configuration registers,
  the guard mode and status registers and a one-bit interrupt.
  Assumes an APB master on I_CLOCK; all inputs synchronous to it.
*/
`timescale 1ns/1ns
`include "twrg_consts.svh"

module twrg_top (
  input  wire logic                I_CLOCK,
  input  wire logic                I_RST_N,
  input  wire logic                I_CLK_EN,
  input  wire logic                I_PSEL,
  input  wire logic                I_PENABLE,
  input  wire logic                I_PWRITE,
  input  wire twrg_pkg::twrg_addr_t I_PADDR,
  input  wire twrg_pkg::twrg_word_t I_PWDATA,
  output twrg_pkg::twrg_word_t      O_PRDATA,
  output logic                      O_PREADY,
  output logic                      O_PSLVERR,
  output logic                      O_IRQ,
  output logic                      O_GUARD_ENABLE,
  output twrg_pkg::twrg_word_t      O_CTRL,
  output twrg_pkg::twrg_word_t      O_CFG
);

  logic                 guard_enable_bit;
  logic                 guard_violation_flag;
  twrg_pkg::twrg_src_t  guard_violation_source;
  twrg_pkg::twrg_word_t ctrl;
  twrg_pkg::twrg_word_t cfg;
  logic                 irq_status;
  logic                 irq_mask;
  logic                 pready;

  // Address decode
  wire hit_ctrl   = I_PADDR == `TWRG_OFS_CTRL;
  wire hit_cfg    = I_PADDR == `TWRG_OFS_CFG;
  wire hit_mode   = I_PADDR == `TWRG_OFS_MODE;
  wire hit_status = I_PADDR == `TWRG_OFS_STATUS;
  wire hit_istat  = I_PADDR == `TWRG_OFS_IRQ_STATUS;
  wire hit_imask  = I_PADDR == `TWRG_OFS_IRQ_MASK;
  wire hit_any    = hit_ctrl | hit_cfg | hit_mode | hit_status
                  | hit_istat | hit_imask;
  wire hit_prot   = hit_ctrl | hit_cfg;

  // Transfer completes at the access edge where pready is high
  wire setup      = I_PSEL & ~I_PENABLE;
  wire access     = I_PSEL & I_PENABLE & pready;
  wire wr_done    = access & I_PWRITE;
  wire rd_done    = access & ~I_PWRITE;

  wire key_ok     = I_PWDATA[`TWRG_KEY_MSB:`TWRG_KEY_LSB] == `TWRG_PASSWORD;
  wire mode_wr    = wr_done & hit_mode;
  wire mode_ok    = mode_wr & key_ok;
  wire prot_wr    = wr_done & hit_prot;
  wire violation  = prot_wr & guard_enable_bit;
  wire prot_allow = prot_wr & ~guard_enable_bit;
  wire status_rd  = rd_done & hit_status;

  wire next_enable = mode_ok ? I_PWDATA[`TWRG_EN_BIT] : guard_enable_bit;
  // Set wins over the read clear
  wire next_flag   = violation | (guard_violation_flag & ~status_rd);
  wire twrg_pkg::twrg_src_t next_source = violation
                   ? {16'h0000, I_PADDR} : guard_violation_source;

  wire irq_clr     = wr_done & hit_istat & I_PWDATA[`TWRG_IRQ_VIOL_BIT];
  wire next_istat  = violation | (irq_status & ~irq_clr);
  wire next_imask  = (wr_done & hit_imask)
                   ? I_PWDATA[`TWRG_IRQ_VIOL_BIT] : irq_mask;
  wire next_irq    = next_istat & next_imask;

  // Key field never reads back
  wire twrg_pkg::twrg_word_t rd_mode   = {31'h0000_0000, guard_enable_bit};
  wire twrg_pkg::twrg_word_t rd_status = {guard_violation_source, 7'h00,
                                          guard_violation_flag};
  wire twrg_pkg::twrg_word_t rd_istat  = {31'h0000_0000, irq_status};
  wire twrg_pkg::twrg_word_t rd_imask  = {31'h0000_0000, irq_mask};
  wire twrg_pkg::twrg_word_t next_rdata;

  assign next_rdata = hit_ctrl   ? ctrl      :
                      hit_cfg    ? cfg       :
                      hit_mode   ? rd_mode   :
                      hit_status ? rd_status :
                      hit_istat  ? rd_istat  :
                      hit_imask  ? rd_imask  : `TWRG_RST_WORD;

  // Guard mode register
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      guard_enable_bit <= 1'b0;
    end else if (I_CLK_EN) begin
      guard_enable_bit <= next_enable;
    end
  end

  // Violation status
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      guard_violation_flag   <= 1'b0;
      guard_violation_source <= `TWRG_RST_SRC;
    end else if (I_CLK_EN) begin
      guard_violation_flag   <= next_flag;
      guard_violation_source <= next_source;
    end
  end

  // Protected registers; writes land only while the guard is off
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl <= `TWRG_RST_WORD;
      cfg  <= `TWRG_RST_WORD;
    end else if (I_CLK_EN && prot_allow) begin
      if (hit_ctrl) begin
        ctrl <= I_PWDATA;
      end else begin
        cfg  <= I_PWDATA;
      end
    end
  end

  // Interrupt status, mask and output
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_status <= `TWRG_RST_IRQ;
      irq_mask   <= `TWRG_RST_IRQ;
      O_IRQ      <= 1'b0;
    end else if (I_CLK_EN) begin
      irq_status <= next_istat;
      irq_mask   <= next_imask;
      O_IRQ      <= next_irq;
    end
  end

  // APB answer: read data captured in setup, one wait-free access cycle
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pready    <= 1'b0;
      O_PRDATA  <= `TWRG_RST_WORD;
      O_PSLVERR <= 1'b0;
    end else if (I_CLK_EN) begin
      pready    <= setup;
      O_PSLVERR <= setup & ~hit_any;
      if (setup && !I_PWRITE) begin
        O_PRDATA <= next_rdata;
      end
    end
  end

  assign O_PREADY       = pready;
  assign O_GUARD_ENABLE = guard_enable_bit;
  assign O_CTRL         = ctrl;
  assign O_CFG          = cfg;

  // Checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence mode_write_s(bit v);
    I_CLK_EN && mode_ok && I_PWDATA[`TWRG_EN_BIT] == v;
  endsequence

  sequence bad_key_s;
    I_CLK_EN && mode_wr && !key_ok;
  endsequence

  sequence prot_hit_s;
    I_CLK_EN && prot_wr && guard_enable_bit;
  endsequence

  guard_off_a: assert property (mode_write_s(1'b0) |=> !O_GUARD_ENABLE)
    else $error("guard not disabled by keyed write");
  guard_on_a: assert property (mode_write_s(1'b1) |=> O_GUARD_ENABLE)
    else $error("guard not enabled by keyed write");
  bad_key_a: assert property (bad_key_s |=> $stable(guard_enable_bit))
    else $error("enable changed on wrong key");
  flag_set_a: assert property (prot_hit_s |=> guard_violation_flag)
    else $error("violation flag not set");
  flag_clear_a: assert property (I_CLK_EN && status_rd && !violation
    |=> !guard_violation_flag)
    else $error("violation flag not cleared by read");
  source_load_a: assert property (prot_hit_s
    |=> guard_violation_source == {16'h0000, $past(I_PADDR)})
    else $error("violation source wrong");
  source_keep_a: assert property ($changed(guard_violation_source)
    |-> $past(violation))
    else $error("source changed without violation");
  prot_hold_a: assert property (prot_hit_s
    |=> $stable(ctrl) && $stable(cfg))
    else $error("protected register written");
  key_read_a: assert property (O_PREADY && !I_PWRITE && hit_mode
    |-> O_PRDATA[31:1] == 31'h0000_0000)
    else $error("key field read back");
  // Ready is a one-cycle answer; a stuck ready would commit twice
  ready_pulse_a: assert property (I_CLK_EN && O_PREADY |=> !O_PREADY)
    else $error("ready held past the access cycle");
  irq_out_a: assert property (I_CLK_EN ##1 1'b1
    |-> O_IRQ == (irq_status & irq_mask))
    else $error("interrupt out of step with status");

endmodule

//--- verification/twrg_top_tb.sv
/*
  Self-checking bench of the write guard, with an integer model.
  Assumes twrg_pkg and twrg_consts.svh on the include path.
*/
`timescale 1ns/1ns
`include "twrg_consts.svh"

module twrg_top_tb;
  logic                 clk = 0;
  logic                 rst_n = 0;
  logic                 psel = 0;
  logic                 pen = 0;
  logic                 pwr = 0;
  twrg_pkg::twrg_addr_t paddr = '0;
  twrg_pkg::twrg_word_t pwdata = '0;
  twrg_pkg::twrg_word_t prdata;
  twrg_pkg::twrg_word_t ctrl_q;
  twrg_pkg::twrg_word_t cfg_q;
  logic                 pready;
  logic                 pslverr;
  logic                 irq;
  logic                 gen;
  int                   error_cnt = 0;
  int                   n_compared = 0;
  int                   cyc = 0;
  int m_en = 0, m_flag = 0, m_src = 0, m_ctrl = 0, m_cfg = 0;
  int m_irq = 0, m_mask = 0;
  twrg_pkg::twrg_addr_t adr[6] = '{`TWRG_OFS_CTRL, `TWRG_OFS_CFG,
    `TWRG_OFS_MODE, `TWRG_OFS_STATUS, `TWRG_OFS_IRQ_STATUS,
    `TWRG_OFS_IRQ_MASK};

  always #20 clk = ~clk;

  twrg_top dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CLK_EN(1'b1),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_IRQ(irq), .O_GUARD_ENABLE(gen),
    .O_CTRL(ctrl_q), .O_CFG(cfg_q));

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A run still going at clock cycle 2000 ends here as a failure; apb gives up on pready after 16 edges
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input twrg_pkg::twrg_word_t seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input twrg_pkg::twrg_addr_t a,
                     input twrg_pkg::twrg_word_t d,
                     output twrg_pkg::twrg_word_t r);
    int   n;
    logic bad;
    n = 0;
    bad = !(a inside {adr});
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 16);
    r = prdata;
    chk({pready, pslverr}, {1'b1, bad});
    psel <= 0;
    pen <= 0;
  endtask

  // Irq output is registered on the same edge as its status; wait two edges anyway
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
    chk(ctrl_q, m_ctrl);
    chk(cfg_q, m_cfg);
    chk({gen, irq}, {m_en[0], m_irq[0] & m_mask[0]});
  endtask

  task automatic wr(input twrg_pkg::twrg_addr_t a,
                    input twrg_pkg::twrg_word_t d);
    twrg_pkg::twrg_word_t x;
    apb(1, a, d, x);
    if (m_en && a inside {`TWRG_OFS_CTRL, `TWRG_OFS_CFG}) begin
      m_flag = 1;
      m_src = a;
      m_irq = 1;
    end else begin
      case (a)
        `TWRG_OFS_CTRL: m_ctrl = d;
        `TWRG_OFS_CFG: m_cfg = d;
        `TWRG_OFS_MODE: if (d[31:8] == `TWRG_PASSWORD) m_en = d[0];
        `TWRG_OFS_IRQ_STATUS: if (d[0]) m_irq = 0;
        `TWRG_OFS_IRQ_MASK: m_mask = d[0];
        default: ;
      endcase
    end
    settle();
  endtask

  task automatic rd(input twrg_pkg::twrg_addr_t a);
    twrg_pkg::twrg_word_t x, e, k;
    k = '1;
    case (a)
      `TWRG_OFS_CTRL: e = m_ctrl;
      `TWRG_OFS_CFG: e = m_cfg;
      `TWRG_OFS_MODE: e = m_en;
      `TWRG_OFS_STATUS: begin
        e = {m_src[23:0], 7'h00, m_flag[0]};
        // Source is only defined while the flag is up
        if (!m_flag) k = 32'h0000_0001;
        m_flag = 0;
      end
      `TWRG_OFS_IRQ_STATUS: e = m_irq;
      `TWRG_OFS_IRQ_MASK: e = m_mask;
      default: e = 0;
    endcase
    apb(0, a, 32'h0000_0000, x);
    chk(x & k, e & k);
    settle();
  endtask

  task automatic done(input string s);
    $display("Test %s done, mismatches %0d", s, error_cnt);
  endtask

  initial begin
    void'($urandom(39));
    repeat (4) @(posedge clk);
    rst_n <= 1;
    foreach (adr[i]) rd(adr[i]);
    done("reset");
    wr(`TWRG_OFS_CTRL, $urandom());
    wr(`TWRG_OFS_CFG, $urandom());
    wr(`TWRG_OFS_MODE, {`TWRG_PASSWORD ^ 24'($urandom_range(1, 255)),
       8'h01});
    rd(`TWRG_OFS_MODE);
    wr(`TWRG_OFS_MODE, {`TWRG_PASSWORD, 8'hFF});
    rd(`TWRG_OFS_MODE);
    done("enable");
    wr(`TWRG_OFS_CTRL, $urandom());
    rd(`TWRG_OFS_STATUS);
    rd(`TWRG_OFS_STATUS);
    wr(`TWRG_OFS_IRQ_MASK, 32'h0000_0001);
    wr(`TWRG_OFS_CFG, $urandom());
    wr(`TWRG_OFS_IRQ_MASK, 32'h0000_0000);
    wr(`TWRG_OFS_IRQ_MASK, 32'h0000_0001);
    rd(`TWRG_OFS_IRQ_STATUS);
    wr(`TWRG_OFS_IRQ_STATUS, 32'h0000_0001);
    wr(`TWRG_OFS_STATUS, $urandom());
    rd(`TWRG_OFS_STATUS);
    done("violation");
    wr(`TWRG_OFS_MODE, {~`TWRG_PASSWORD, 8'h00});
    wr(`TWRG_OFS_MODE, {`TWRG_PASSWORD, 8'h00});
    wr(`TWRG_OFS_CTRL, $urandom());
    rd(`TWRG_OFS_CTRL);
    wr(8'h10, $urandom());
    rd(8'h10);
    rd(`TWRG_OFS_STATUS);
    done("disable");
    // Mid-run reset must bring every register back to zero
    wr(`TWRG_OFS_MODE, {`TWRG_PASSWORD, 8'h01});
    wr(`TWRG_OFS_CFG, $urandom());
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    m_en = 0;
    m_flag = 0;
    m_src = 0;
    m_ctrl = 0;
    m_cfg = 0;
    m_irq = 0;
    m_mask = 0;
    foreach (adr[i]) rd(adr[i]);
    done("reset again");
    tally_and_finish();
  end
endmodule
